// File: aux_pkg.sv
// constants shared by the auxiliary serial output and delay port
package aux_pkg;
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   // control register field positions
   localparam int CTRL_W = 14;
   localparam int LSEL_LSB = 0;
   localparam int RSEL_LSB = 2;
   localparam int ON_BIT = 4;
   localparam int FMT_BIT = 5;
   localparam int ANALOG_BIT = 6;
   localparam int PDC_BIT = 7;
   localparam int PDG_BIT = 8;
   localparam int HALF_BIT = 9;
   localparam int SYS_LSB = 10;
   localparam int MODE_LSB = 12;
   // left slot channel a, right slot channel b, port off, delay port off
   localparam logic [13:0] CTRL_RESET = 14'h0004;
   // status register field positions
   localparam int ST_WARN_BIT = 0;
   localparam int ST_FORCED_BIT = 1;
   // source select codes
   localparam logic [1:0] SRC_A = 2'h0;
   localparam logic [1:0] SRC_B = 2'h1;
   localparam logic [1:0] SRC_SUB = 2'h2;
   localparam logic [1:0] SRC_XOVER = 2'h3;
   // delay port modes
   localparam logic [1:0] DLY_OFF = 2'h0;
   localparam logic [1:0] DLY_LOOP = 2'h1;
   localparam logic [1:0] DLY_WARN = 2'h2;
   // system clock choices
   localparam logic [1:0] SYS_18M432 = 2'h0;
   // sample width and analog-mode clock ratios
   localparam int WORD_W = 24;
   localparam logic [2:0] BCLK_HIGH_FROM = 3'h4;
   localparam logic [5:0] FRAME_LAST_48 = 6'h2f;
   localparam logic [5:0] FRAME_LAST_64 = 6'h3f;
   localparam logic [5:0] HALF_48 = 6'h18;
   localparam logic [5:0] HALF_64 = 6'h20;
   // configuration bits carried across to the link side
   localparam int CFG_W = 10;
   localparam int XFER_W = CFG_W + 2 * WORD_W;
endpackage

// File: aux_rx_model.sv
// behavioural receiver standing in for the external audio device on the aux pins
`timescale 1ns/1ps
module aux_rx_model (
   // link clock and aux pins
   input wire logic i_link_clk,
   input wire logic i_bit_clock,
   input wire logic i_frame_clock,
   input wire logic i_data,
   input wire logic i_i2s,
   // captured words and measured timing
   output logic [23:0] o_left,
   output logic [23:0] o_right,
   output logic [7:0] o_half_bits,
   output logic [7:0] o_bclk_period,
   output logic [15:0] o_frames
);
   logic frame_q = 1'b0; // frame level seen at the last bit
   logic bclk_q = 1'b0; // bit clock seen at the last link edge
   logic [7:0] idx_q = 8'h00; // bit index within the current half
   logic [23:0] sh_q = 24'h0; // word being shifted in
   logic [7:0] per_q = 8'h00; // link cycles since the last rising bit clock
   // outputs start clear so the bench never reads an unknown
   initial
   begin
      o_left = 24'h0;
      o_right = 24'h0;
      o_half_bits = 8'h00;
      o_bclk_period = 8'h00;
      o_frames = 16'h0000;
   end
   // sample on the rising bit clock, the device moves data on the falling one
   always @(posedge i_bit_clock)
   begin
      if (i_frame_clock !== frame_q)
      begin
         // a frame edge closes the half just received, low half is left
         if (frame_q)
         begin
            o_right <= sh_q;
            o_frames <= o_frames + 16'h0001;
         end
         else
            o_left <= sh_q;
         o_half_bits <= idx_q + 8'h01;
         frame_q <= i_frame_clock;
         idx_q <= 8'h00;
         sh_q <= i_i2s ? 24'h0 : {23'h0, i_data};
      end
      else
      begin
         idx_q <= idx_q + 8'h01;
         // i2s spends one bit after the edge, so its word ends one bit later
         if (idx_q + 8'h01 < (i_i2s ? 8'h19 : 8'h18))
            sh_q <= {sh_q[22:0], i_data};
      end
   end
   // count link cycles between rising bit clock edges
   always @(posedge i_link_clk)
   begin
      bclk_q <= i_bit_clock;
      if (i_bit_clock && !bclk_q)
      begin
         o_bclk_period <= per_q;
         per_q <= 8'h01;
      end
      else
         per_q <= per_q + 8'h01;
   end
endmodule // aux_rx_model

// File: aux_serial_out.sv
// auxiliary serial audio output with delay and warning port mode control
`timescale 1ns/1ps
module aux_serial_out (
   // bus clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // processed audio sources, bus clock domain
   input wire logic [23:0] i_chan_a,
   input wire logic [23:0] i_chan_b,
   input wire logic [23:0] i_chan_sub,
   input wire logic [23:0] i_xover_b_lpf,
   input wire logic [23:0] i_xover_b_hpf,
   // serial input port clocks (pins)
   input wire logic i_sp_bit_clock,
   input wire logic i_sp_frame_clock,
   // link clock: the system clock the aux clocks derive from
   input wire logic i_system_clock_in,
   // auxiliary serial output pins
   output logic o_aux_bit_clock_out,
   output logic o_aux_frame_clock_out,
   output logic o_aux_serial_data_out,
   // delay and warning port pins
   output logic o_delay_loop_data_out,
   output logic o_delay_loop_data_oe,
   input wire logic i_delay_in_or_warning_pin
);
   // bus clock domain state
   typedef struct packed {
      logic [13:0] ctrl; // control register
      logic warn_m; // warning pin sync stage 1
      logic warn_s; // warning pin sync stage 2
      logic [31:0] rdata; // read data, valid one cycle after strobe
   } bus_s;
   // link clock domain state
   typedef struct packed {
      logic spb_m; // input bit clock sync stage 1
      logic spb_s; // input bit clock sync stage 2
      logic spb_p; // previous synced bit clock
      logic spl_m; // input frame clock sync stage 1
      logic spl_s; // input frame clock sync stage 2
      logic spl_p; // previous synced frame clock
      logic [2:0] div; // analog-mode divider
      logic [5:0] fcnt; // analog-mode bit within frame
      logic bclk; // internal bit clock
      logic lrck; // internal frame clock, low is left
      logic lrck_seen; // frame clock level at last falling bit edge
      logic [5:0] bitcnt; // bit within current channel
      logic [23:0] word; // sample being shifted out
      logic sdata; // internal serial data
      logic out_bclk;
      logic out_lrck;
      logic out_sd;
      logic out_dd;
      logic out_doe;
   } link_s;

   bus_s bq, bd;
   link_s lq, ld;
   logic [57:0] xfer_src; // configuration and samples toward link side
   logic [57:0] xfer_dst; // same, on the link side
   logic [23:0] left_pick; // left slot source
   logic [23:0] right_pick; // right slot source
   logic forced_off; // outputs held low, bus view
   // link-side configuration
   logic c_on, c_fmt_i2s, c_analog, c_pdc, c_pdg, c_half;
   logic [1:0] c_sys, c_mode;
   logic [23:0] c_left, c_right;
   logic c_active; // port enabled and not powered down
   logic bclk_n, lrck_n, fall; // next clocks and falling bit edge
   logic [5:0] frame_last, frame_half;
   logic [5:0] pos; // word bit position being sent

   // source selection shared by both slots
   function automatic logic [23:0] pick_source(input logic [1:0] sel, input logic [23:0] xover);
      logic [23:0] r;
      r = i_chan_a;
      case (sel)
         aux_pkg::SRC_A: r = i_chan_a;
         aux_pkg::SRC_B: r = i_chan_b;
         aux_pkg::SRC_SUB: r = i_chan_sub;
         default: r = xover;
      endcase
      return r;
   endfunction

   // power-down forcing only applies while the analog path feeds the port
   function automatic logic gated_off(input logic on, input logic analog, input logic pdc, input logic pdg);
      return !on || (analog && (pdc || pdg));
   endfunction

   assign left_pick = pick_source(bq.ctrl[aux_pkg::LSEL_LSB +: 2], i_xover_b_lpf);
   assign right_pick = pick_source(bq.ctrl[aux_pkg::RSEL_LSB +: 2], i_xover_b_hpf);
   assign forced_off = gated_off(bq.ctrl[aux_pkg::ON_BIT], bq.ctrl[aux_pkg::ANALOG_BIT],
                                 bq.ctrl[aux_pkg::PDC_BIT], bq.ctrl[aux_pkg::PDG_BIT]);
   assign xfer_src = {bq.ctrl[13:4], right_pick, left_pick};

   // register port and warning pin, bus clock domain
   always_comb
   begin
      bd = bq;
      bd.warn_m = i_delay_in_or_warning_pin;
      bd.warn_s = bq.warn_m;
      bd.rdata = 32'h0;
      if (i_wr && i_addr == aux_pkg::ADDR_CTRL)
         bd.ctrl = i_wdata[13:0];
      if (i_rd)
      begin
         case (i_addr)
            aux_pkg::ADDR_CTRL: bd.rdata = {18'h0, bq.ctrl};
            aux_pkg::ADDR_STATUS:
            begin
               // warning is active low and only meaningful in warning mode
               bd.rdata[aux_pkg::ST_WARN_BIT] = (bq.ctrl[aux_pkg::MODE_LSB +: 2] == aux_pkg::DLY_WARN)
                                                 && !bq.warn_s;
               bd.rdata[aux_pkg::ST_FORCED_BIT] = forced_off;
            end
            default: bd.rdata = 32'h0; // unmapped reads return zero
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bq <= '0;
         bq.ctrl <= aux_pkg::CTRL_RESET;
      end
      else
         bq <= bd;
   end

   assign o_rdata = bq.rdata;

   // configuration and samples cross as one coherent word
   word_handshake_sync #(.W(aux_pkg::XFER_W)) u_xfer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_data(xfer_src),
      .i_dst_clk(i_system_clock_in),
      .o_data(xfer_dst)
   );

   assign {c_mode, c_sys, c_half, c_pdg, c_pdc, c_analog, c_fmt_i2s, c_on} = xfer_dst[57:48];
   assign c_right = xfer_dst[47:24];
   assign c_left = xfer_dst[23:0];
   assign c_active = !gated_off(c_on, c_analog, c_pdc, c_pdg);
   assign frame_last = (c_sys == aux_pkg::SYS_18M432) ? aux_pkg::FRAME_LAST_48 : aux_pkg::FRAME_LAST_64;
   assign frame_half = (c_sys == aux_pkg::SYS_18M432) ? aux_pkg::HALF_48 : aux_pkg::HALF_64;

   // clock generation and serialiser, link clock domain
   always_comb
   begin
      ld = lq;
      ld.spb_m = i_sp_bit_clock;
      ld.spb_s = lq.spb_m;
      ld.spb_p = lq.spb_s;
      ld.spl_m = i_sp_frame_clock;
      ld.spl_s = lq.spl_m;
      ld.spl_p = lq.spl_s;
      bclk_n = lq.bclk;
      lrck_n = lq.lrck;
      pos = 6'h0;
      ld.div = 3'h0; // restart the divider so the first analog bit clock is full length
      if (c_analog)
      begin
         // bit clock is the system clock over eight, high in the upper half
         ld.div = lq.div + 3'h1;
         bclk_n = (ld.div >= aux_pkg::BCLK_HIGH_FROM);
      end
      else if (c_half)
      begin
         // half rate: one output level change per input rising edge
         if (lq.spb_s && !lq.spb_p)
            bclk_n = ~lq.bclk;
         if (lq.spl_s && !lq.spl_p)
            lrck_n = ~lq.lrck;
      end
      else
      begin
         bclk_n = lq.spb_s;
         lrck_n = lq.spl_s;
      end
      fall = lq.bclk && !bclk_n;
      if (fall && c_analog)
      begin
         ld.fcnt = (lq.fcnt == frame_last) ? 6'h0 : lq.fcnt + 6'h1;
         lrck_n = (ld.fcnt >= frame_half);
      end
      // data changes on the falling bit clock so the far end samples on the rising one
      if (fall)
      begin
         if (lrck_n != lq.lrck_seen)
         begin
            ld.lrck_seen = lrck_n;
            ld.bitcnt = 6'h0;
            ld.word = lrck_n ? c_right : c_left;
         end
         else if (lq.bitcnt != 6'h3f)
            ld.bitcnt = lq.bitcnt + 6'h1;
         // i2s delays the msb by one bit after the frame edge
         pos = c_fmt_i2s ? ld.bitcnt - 6'h1 : ld.bitcnt;
         if (c_fmt_i2s && ld.bitcnt == 6'h0)
            ld.sdata = 1'b0;
         else if (pos < 6'd24)
            ld.sdata = ld.word[5'd23 - pos[4:0]];
         else
            ld.sdata = 1'b0;
      end
      ld.bclk = bclk_n;
      ld.lrck = lrck_n;
      // outputs are forced low rather than tri-stated so the far end sees a quiet bus
      ld.out_bclk = c_active && bclk_n;
      ld.out_lrck = c_active && lrck_n;
      ld.out_sd = c_active && ld.sdata;
      // the delay loop reuses the aux clocks, so it is silent while the port is off
      ld.out_doe = (c_mode == aux_pkg::DLY_LOOP);
      ld.out_dd = ld.out_doe && c_active && ld.sdata;
   end

   always_ff @(posedge i_system_clock_in or posedge i_rst)
   begin
      if (i_rst)
         lq <= '0;
      else
         lq <= ld;
   end

   assign o_aux_bit_clock_out = lq.out_bclk;
   assign o_aux_frame_clock_out = lq.out_lrck;
   assign o_aux_serial_data_out = lq.out_sd;
   assign o_delay_loop_data_out = lq.out_dd;
   assign o_delay_loop_data_oe = lq.out_doe;

   // bus domain checks
   property p_reset_route;
      @(posedge i_clk) disable iff (i_rst)
      $past(i_rst) |-> bq.ctrl == aux_pkg::CTRL_RESET;
   endproperty
   a_reset_route: assert property (p_reset_route) else $error("routing not at reset default");

   property p_left_xover;
      @(posedge i_clk) disable iff (i_rst)
      (bq.ctrl[1:0] == aux_pkg::SRC_XOVER) |-> xfer_src[23:0] == i_xover_b_lpf;
   endproperty
   a_left_xover: assert property (p_left_xover) else $error("left slot not low-pass");

   property p_right_sub;
      @(posedge i_clk) disable iff (i_rst)
      (bq.ctrl[3:2] == aux_pkg::SRC_SUB) |-> xfer_src[47:24] == i_chan_sub;
   endproperty
   a_right_sub: assert property (p_right_sub) else $error("right slot not sub");

   // link domain checks
   sequence s_high_four;
      lq.bclk [*4];
   endsequence
   property p_analog_bclk;
      @(posedge i_system_clock_in) disable iff (i_rst || !c_analog)
      (c_analog && $rose(lq.bclk) && $stable(c_analog)) |-> s_high_four ##1 !lq.bclk;
   endproperty
   a_analog_bclk: assert property (p_analog_bclk) else $error("analog bit clock not divide by eight");

   property p_frame_wrap;
      @(posedge i_system_clock_in) disable iff (i_rst)
      (c_analog && fall && lq.fcnt == frame_last) |=> lq.fcnt == 6'h0 && !lq.lrck;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame length wrong");

   property p_follow_input;
      @(posedge i_system_clock_in) disable iff (i_rst)
      (!c_analog && !c_half) |=> lq.bclk == $past(lq.spb_s);
   endproperty
   a_follow_input: assert property (p_follow_input) else $error("bit clock not following input");

   property p_first_bit;
      @(posedge i_system_clock_in) disable iff (i_rst)
      ($changed(lq.lrck_seen) && $stable(c_fmt_i2s)) |-> lq.sdata == (c_fmt_i2s ? 1'b0 : lq.word[23]);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first bit of channel wrong");

   property p_left_half;
      @(posedge i_system_clock_in) disable iff (i_rst)
      ($changed(lq.lrck_seen) && !lq.lrck_seen && $stable(xfer_dst)) |-> lq.word == c_left;
   endproperty
   a_left_half: assert property (p_left_half) else $error("left sample not loaded");

   property p_forced_low;
      @(posedge i_system_clock_in) disable iff (i_rst)
      !c_active |=> !o_aux_bit_clock_out && !o_aux_frame_clock_out && !o_aux_serial_data_out;
   endproperty
   a_forced_low: assert property (p_forced_low) else $error("outputs not held low");

   property p_delay_float;
      @(posedge i_system_clock_in) disable iff (i_rst)
      (c_mode != aux_pkg::DLY_LOOP) |=> !o_delay_loop_data_oe;
   endproperty
   a_delay_float: assert property (p_delay_float) else $error("delay output driven");

   property p_loop_data;
      @(posedge i_system_clock_in) disable iff (i_rst)
      o_delay_loop_data_oe |-> o_delay_loop_data_out == o_aux_serial_data_out;
   endproperty
   a_loop_data: assert property (p_loop_data) else $error("delay data differs from aux data");
endmodule // aux_serial_out

// File: aux_serial_out_bench.sv
// self-checking bench for the auxiliary serial output and delay port
`timescale 1ns/1ps
module aux_serial_out_bench;
   // clocks, bus and pins
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_system_clock_in = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic [23:0] src [5] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0}; // a, b, sub, lpf, hpf
   logic sp_bclk = 1'b0;
   logic sp_frame = 1'b0;
   logic warn_n = 1'b1; // active-low warning input
   logic bclk, frame, sdata, dly, dly_oe;
   logic i2s_q = 1'b0; // format the bench last set, told to the receiver
   logic [23:0] m_left, m_right;
   logic [7:0] m_half, m_per;
   logic [15:0] m_frames;
   int sp_cnt = 0;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #2.5 i_clk = ~i_clk;
   always #80 i_system_clock_in = ~i_system_clock_in;
   // serial input clocks: bit toggles every link cycle, 25 bits per half so an i2s word fits whole
   always @(negedge i_system_clock_in)
   begin
      sp_bclk <= ~sp_bclk;
      sp_cnt <= (sp_cnt == 49) ? 0 : sp_cnt + 1;
      if (sp_cnt == 49)
         sp_frame <= ~sp_frame;
   end
   aux_serial_out aux_serial_out_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_a(src[0]), .i_chan_b(src[1]),
      .i_chan_sub(src[2]), .i_xover_b_lpf(src[3]), .i_xover_b_hpf(src[4]), .i_sp_bit_clock(sp_bclk),
      .i_sp_frame_clock(sp_frame), .i_system_clock_in(i_system_clock_in), .o_aux_bit_clock_out(bclk),
      .o_aux_frame_clock_out(frame), .o_aux_serial_data_out(sdata), .o_delay_loop_data_out(dly),
      .o_delay_loop_data_oe(dly_oe), .i_delay_in_or_warning_pin(warn_n));
   aux_rx_model aux_rx_model_inst (.i_link_clk(i_system_clock_in), .i_bit_clock(bclk), .i_frame_clock(frame),
      .i_data(sdata), .i_i2s(i2s_q), .o_left(m_left), .o_right(m_right), .o_half_bits(m_half),
      .o_bclk_period(m_per), .o_frames(m_frames));
   // verdict and end of run
   task automatic test_done;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle write and read strobes, read data taken in the following cycle
   task automatic wr(input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= aux_pkg::ADDR_CTRL;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i2s_q <= d[aux_pkg::FMT_BIT];
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // config reaches the link side within ten link cycles
   task automatic settle;
      repeat (12) @(posedge i_system_clock_in);
   endtask
   task automatic wait_frames(input int n);
      int start;
      start = m_frames;
      for (int t = 0; t < 60000 && int'(m_frames) - start < n; t++)
         @(posedge i_clk);
      if (int'(m_frames) - start < n)
      begin
         chk("frame wait", 32'h1, 32'h0);
         test_done();
      end
   endtask
   function automatic logic [31:0] cfg(input logic [1:0] l, r, input logic on, f, ana, pdc, pdg, half,
      input logic [1:0] sys, mode);
      cfg = 32'h0;
      cfg[aux_pkg::LSEL_LSB +: 2] = l;
      cfg[aux_pkg::RSEL_LSB +: 2] = r;
      cfg[aux_pkg::ON_BIT] = on;
      cfg[aux_pkg::FMT_BIT] = f;
      cfg[aux_pkg::ANALOG_BIT] = ana;
      cfg[aux_pkg::PDC_BIT] = pdc;
      cfg[aux_pkg::PDG_BIT] = pdg;
      cfg[aux_pkg::HALF_BIT] = half;
      cfg[aux_pkg::SYS_LSB +: 2] = sys;
      cfg[aux_pkg::MODE_LSB +: 2] = mode;
   endfunction
   // word the selected source should carry; code 3 differs per slot
   function automatic logic [31:0] pick(input logic [1:0] sel, input logic right);
      pick = {8'h00, (sel == 2'h3 && right) ? src[4] : src[sel]};
   endfunction
   // main sequence
   initial
   begin
      logic [31:0] d;
      logic [31:0] c;
      void'($urandom(32'h1354c3df));
      repeat (12) @(posedge i_system_clock_in);
      @(posedge i_clk);
      i_rst <= 1'b0;
      rd(aux_pkg::ADDR_CTRL, d);
      chk("ctrl reset", {18'h0, aux_pkg::CTRL_RESET}, d);
      rd(8'h08, d);
      chk("unmapped read", 32'h0, d);
      chk("pins after reset", 32'h0, {bclk, frame, sdata, dly_oe});
      // every source code in both slots, both formats, digital mode
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clk);
         for (int k = 0; k < 5; k++)
            src[k] <= 24'($urandom());
         c = cfg(2'(i), 2'(3 - i), 1'b1, i[0], 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, aux_pkg::DLY_OFF);
         wr(c);
         rd(aux_pkg::ADDR_CTRL, d);
         chk("ctrl readback", c, d);
         settle();
         wait_frames(2);
         chk("left word", pick(2'(i), 1'b0), {8'h0, m_left});
         chk("right word", pick(2'(3 - i), 1'b1), {8'h0, m_right});
         chk("digital half bits", 32'd25, {24'h0, m_half});
         chk("digital bit period", 32'd2, {24'h0, m_per});
      end
      // half-rate digital clocks
      wr(cfg(2'h0, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, aux_pkg::DLY_OFF));
      settle();
      repeat (24) @(posedge i_system_clock_in);
      chk("half rate bit period", 32'd4, {24'h0, m_per});
      // analog mode at 18.432 and 27.000
      for (int s = 0; s < 2; s++)
      begin
         wr(cfg(2'h2, 2'h3, 1'b1, s[0], 1'b1, 1'b0, 1'b0, 1'b0, 2'(2 * s), aux_pkg::DLY_OFF));
         settle();
         wait_frames(2);
         chk("analog left", pick(2'h2, 1'b0), {8'h0, m_left});
         chk("analog right", pick(2'h3, 1'b1), {8'h0, m_right});
         chk("analog half bits", s ? 32'd32 : 32'd24, {24'h0, m_half});
         chk("analog bit period", 32'd8, {24'h0, m_per});
      end
      // forced-low cases: port off, converter and global power-down; last case digital, not forced
      for (int f = 0; f < 4; f++)
      begin
         wr(cfg(2'h0, 2'h1, f != 0, 1'b0, f == 1 || f == 2, f == 1 || f == 3, f >= 2, 1'b0, 2'h0,
            aux_pkg::DLY_OFF));
         settle();
         rd(aux_pkg::ADDR_STATUS, d);
         chk("forced status", f != 3, 32'(d[aux_pkg::ST_FORCED_BIT]));
         repeat (4)
         begin
            repeat (3) @(posedge i_system_clock_in);
            #1 if (f < 3)
               chk("forced pins", 32'h0, {bclk, frame, sdata});
         end
         if (f == 3)
            chk("digital ignores power-down", 32'd2, {24'h0, m_per});
      end
      // delay port modes, analog clocks running
      for (int m = 0; m < 4; m++)
      begin
         wr(cfg(2'h0, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'(m)));
         settle();
         chk("delay oe", m == 1, dly_oe);
         for (int t = 0; t < 64 && m == 1; t++)
         begin
            @(posedge i_system_clock_in);
            // compare mid-bit only, while the bit clock is high
            #1 if (bclk === 1'b1)
               chk("delay data", sdata, dly);
         end
         if (m == 2)
         begin
            @(posedge i_clk);
            warn_n <= 1'b0;
            repeat (8) @(posedge i_clk);
            rd(aux_pkg::ADDR_STATUS, d);
            chk("warning on", 32'h1, 32'(d[aux_pkg::ST_WARN_BIT]));
            @(posedge i_clk);
            warn_n <= 1'b1;
            repeat (8) @(posedge i_clk);
            rd(aux_pkg::ADDR_STATUS, d);
            chk("warning off", 32'h0, 32'(d[aux_pkg::ST_WARN_BIT]));
         end
      end
      test_done();
   end
endmodule // aux_serial_out_bench

// File: word_handshake_sync.sv
// two-phase toggle handshake carrying one word from the bus clock to the link clock
`timescale 1ns/1ps
module word_handshake_sync #(
   parameter int W = 58
) (
   // source side
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_data,
   // destination side
   input wire logic i_dst_clk,
   output logic [W-1:0] o_data
);
   typedef struct packed {
      logic req;
      logic ack_m;
      logic ack_s;
      logic [W-1:0] data;
   } src_s;
   typedef struct packed {
      logic req_m;
      logic req_s;
      logic ack;
      logic [W-1:0] data;
   } dst_s;
   src_s sq, sd; // source state
   dst_s dq, dd; // destination state

   // source: new word launched only once the previous one is acknowledged
   always_comb
   begin
      sd = sq;
      sd.ack_m = dq.ack;
      sd.ack_s = sq.ack_m;
      if (sq.ack_s == sq.req)
      begin
         sd.data = i_data;
         sd.req = ~sq.req;
      end
   end

   // destination: data is stable while the request toggle travels
   always_comb
   begin
      dd = dq;
      dd.req_m = sq.req;
      dd.req_s = dq.req_m;
      if (dq.req_s != dq.ack)
      begin
         dd.data = sq.data;
         dd.ack = dq.req_s;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sq <= '0;
      else
         sq <= sd;
   end

   always_ff @(posedge i_dst_clk or posedge i_rst)
   begin
      if (i_rst)
         dq <= '0;
      else
         dq <= dd;
   end

   assign o_data = dq.data;
endmodule // word_handshake_sync
